// ### common/sensor_boot_pkg.sv
package sensor_boot_pkg;

  // ----------------------------------------------------------------------
  // identity and sizes
  // ----------------------------------------------------------------------
  // arbitrary identity value, not tied to any real part
  localparam logic [7:0] HW_IDENTITY_VAL = 8'h5C;
  localparam int         RESULT_BYTES    = 4;

  // ----------------------------------------------------------------------
  // sample timing
  // ----------------------------------------------------------------------
  localparam int SAMPLE_PERIOD_US  = 1000;
  localparam int CLK_MHZ           = 25;
  localparam int SAMPLE_PERIOD_CYC = SAMPLE_PERIOD_US * CLK_MHZ;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] DRIVE_RST  = 3'h0;
  localparam logic       IRQ_EN_RST = 1'b0;

  typedef enum logic [0:0] {
    ST_BOOT = 1'b0,
    ST_APP  = 1'b1
  } mode_t;

  // host request group
  typedef struct packed {
    logic       launch;
    logic       cfgWrite;
    logic [2:0] cfgDrive;
    logic       cfgIrqEn;
    logic       readStart;
    logic       readNext;
  } hostReq_t;

  // status presented to host
  typedef struct packed {
    logic fwValid;
    logic appMode;
    logic dataReady;
  } status_t;

endpackage

// ### rtl/boot_to_app_init.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - power up in boot, stay until launch
// - boot reports firmware image validity flag
// - launch write moves boot to application only while a firmware image is present
// - application shows firmware valid and mode
// - results sent most significant byte first
module boot_to_app_init (
  input  wire logic                       sys_clk,
  input  wire logic                       nrst,
  input  wire logic                       fwImagePresent,
  input  wire sensor_boot_pkg::hostReq_t  hostReq,
  input  wire logic [15:0]                equivCarbonDioxide,
  input  wire logic [15:0]                volatileOrganicTotal,
  output logic [7:0]                      hardwareIdentity,
  output sensor_boot_pkg::status_t        status,
  output logic [2:0]                      driveMode,
  output logic                            irqOutLow,
  output logic [7:0]                      readByte,
  output logic                            readValid
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    sensor_boot_pkg::mode_t mode;
    logic [2:0]             drive;
    logic                   irqEn;
    logic                   ready;
    logic [24:0]            sampleCnt;
    logic [31:0]            sample;
  } core_t;

  core_t state_ff;
  core_t nxt_state;
  logic  inApp;
  logic  sampleTick;
  logic  loadRead;
  logic  launchOk;
  logic  cfgOk;
  logic  stepOk;
  logic  timerRun;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // mode decode feeds the gates, the timer and the status flags
  function automatic logic is_app(input sensor_boot_pkg::mode_t m);
    return (m == sensor_boot_pkg::ST_APP);
  endfunction

  // a zero drive setting parks the sample timer
  function automatic logic drive_active(input logic [2:0] drv);
    return (drv != 3'h0);
  endfunction

  // last count of a period, so exactly one tick lands per full period
  function automatic logic period_end(input logic [24:0] cnt);
    return (cnt == 25'(sensor_boot_pkg::SAMPLE_PERIOD_CYC - 1));
  endfunction

  // carbon dioxide reading goes in the upper half, so it leaves first
  function automatic logic [31:0] pack_sample(
    input logic [15:0] hi,
    input logic [15:0] lo
  );
    return {hi, lo};
  endfunction

  // low level of the interrupt pin only while enabled and a sample waits
  function automatic logic irq_level(input logic en, input logic rdy);
    return ~(en & rdy);
  endfunction

  // ----------------------------------------------------------------------
  // request qualification
  // ----------------------------------------------------------------------
  assign inApp    = is_app(state_ff.mode);
  // launch without a valid image would run garbage, so refuse it
  assign launchOk = hostReq.launch && fwImagePresent && !inApp;
  // boot drops every measurement request without any sign of refusal
  assign cfgOk    = hostReq.cfgWrite && inApp;
  assign loadRead = hostReq.readStart && inApp;
  assign stepOk   = hostReq.readNext && inApp;

  // sampling only runs once measurement has been enabled by a drive setting
  assign timerRun   = inApp && drive_active(state_ff.drive);
  assign sampleTick = timerRun && period_end(state_ff.sampleCnt);

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;

    // mode and configuration
    unique case (state_ff.mode)
      sensor_boot_pkg::ST_BOOT: begin
        if (launchOk) begin
          nxt_state.mode = sensor_boot_pkg::ST_APP;
        end
      end
      sensor_boot_pkg::ST_APP: begin
        if (cfgOk) begin
          nxt_state.drive = hostReq.cfgDrive;
          nxt_state.irqEn = hostReq.cfgIrqEn;
        end
      end
    endcase

    // sample timer: held at zero while parked, wraps on each tick
    if (!timerRun || sampleTick) begin
      nxt_state.sampleCnt = 25'h0;
    end else begin
      nxt_state.sampleCnt = state_ff.sampleCnt + 25'h1;
    end
    // a new sample beats the clear done by the read in the same cycle
    if (sampleTick) begin
      nxt_state.ready  = 1'b1;
      nxt_state.sample = pack_sample(equivCarbonDioxide, volatileOrganicTotal);
    end else if (loadRead) begin
      nxt_state.ready = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff.mode      <= sensor_boot_pkg::ST_BOOT;
      state_ff.drive     <= sensor_boot_pkg::DRIVE_RST;
      state_ff.irqEn     <= sensor_boot_pkg::IRQ_EN_RST;
      state_ff.ready     <= 1'b0;
      state_ff.sampleCnt <= 25'h0;
      state_ff.sample    <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign hardwareIdentity = sensor_boot_pkg::HW_IDENTITY_VAL;
  assign status.fwValid   = inApp ? 1'b1 : fwImagePresent;
  assign status.appMode   = inApp;
  assign status.dataReady = state_ff.ready;
  assign driveMode        = state_ff.drive;
  assign irqOutLow        = irq_level(state_ff.irqEn, state_ff.ready);

  // a fresh read restarts the stream from the high byte, even mid-word
  result_serializer u_ser (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .load      (loadRead),
    .word      (state_ff.sample),
    .next      (stepOk),
    .byteOut   (readByte),
    .byteValid (readValid)
  );

endmodule

`default_nettype wire

// ### rtl/result_serializer.sv
`timescale 1ns/1ps
`default_nettype none

// streams a result word out most significant byte first
module result_serializer (
  input  wire logic                                    sys_clk,
  input  wire logic                                    nrst,
  input  wire logic                                    load,
  input  wire logic [8*sensor_boot_pkg::RESULT_BYTES-1:0] word,
  input  wire logic                                    next,
  output logic [7:0]                                   byteOut,
  output logic                                         byteValid
);

  typedef struct packed {
    logic [8*sensor_boot_pkg::RESULT_BYTES-1:0] shift;
    logic [2:0]                                 left;
  } ser_t;

  ser_t state_ff;
  ser_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (load) begin
      nxt_state.shift = word;
      nxt_state.left  = 3'(sensor_boot_pkg::RESULT_BYTES);
    end else if (next && state_ff.left != 3'h0) begin
      nxt_state.shift = {state_ff.shift[8*sensor_boot_pkg::RESULT_BYTES-9:0], 8'h00};
      nxt_state.left  = state_ff.left - 3'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign byteOut   = state_ff.shift[8*sensor_boot_pkg::RESULT_BYTES-1 -: 8];
  assign byteValid = (state_ff.left != 3'h0);

endmodule

`default_nettype wire

// ### tb/boot_to_app_init_checker.sv
`timescale 1ns/1ps
`default_nettype none
module boot_to_app_init_checker (
  input wire logic                      sys_clk,
  input wire logic                      nrst,
  input wire logic                      fwImagePresent,
  input wire sensor_boot_pkg::hostReq_t hostReq,
  input wire logic [15:0]               equivCarbonDioxide,
  input wire logic [7:0]                hardwareIdentity,
  input wire sensor_boot_pkg::status_t  status,
  input wire logic [2:0]                driveMode,
  input wire logic                      irqOutLow,
  input wire logic [7:0]                readByte,
  input wire logic                      readValid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_rdReq; hostReq.readStart && status.appMode; endsequence
  sequence s_first; readValid && readByte == equivCarbonDioxide[15:8]; endsequence
  property p_stay; !status.appMode && !hostReq.launch |=> !status.appMode; endproperty
  a_stay: assert property (p_stay) else $error("left boot without launch");
  property p_go; hostReq.launch && fwImagePresent |=> status.appMode; endproperty
  a_go: assert property (p_go) else $error("launch not taken");
  property p_fwb; !status.appMode |-> status.fwValid == fwImagePresent; endproperty
  a_fwb: assert property (p_fwb) else $error("boot image flag wrong");
  property p_fwa; status.appMode |-> status.fwValid; endproperty
  a_fwa: assert property (p_fwa) else $error("app without valid flag");
  property p_cfg; !status.appMode |-> driveMode == 3'h0 && !readValid; endproperty
  a_cfg: assert property (p_cfg) else $error("boot accepted request");
  property p_rd; s_rdReq |=> s_first; endproperty
  a_rd: assert property (p_rd) else $error("first byte not high byte");
  property p_id; hardwareIdentity == sensor_boot_pkg::HW_IDENTITY_VAL; endproperty
  a_id: assert property (p_id) else $error("identity wrong");
  property p_irq; !status.dataReady |-> irqOutLow; endproperty
  a_irq: assert property (p_irq) else $error("irq low with no data");
endmodule
`default_nettype wire

// ### tb/boot_to_app_init_test.sv
`timescale 1ns/1ps
`default_nettype none
module boot_to_app_init_test;
  logic sys_clk = 0, nrst = 0, fwImagePresent = 0, irqOutLow, readValid;
  logic [15:0] equivCarbonDioxide = 16'h0000, volatileOrganicTotal = 16'h0000;
  logic [7:0] hardwareIdentity, readByte;
  logic [2:0] driveMode, d;
  sensor_boot_pkg::hostReq_t hostReq;
  sensor_boot_pkg::status_t  status;
  int miscompares = 0, n_checks = 0, i;
  boot_to_app_init dut (.*);
  host_model h (.sys_clk(sys_clk), .hostReq(hostReq));
  initial forever #20 sys_clk = ~sys_clk;
  function automatic logic [7:0] exp_byte(int k);
    return 8'({equivCarbonDioxide, volatileOrganicTotal} >> (24 - 8 * k));
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    i = $urandom(80);
    equivCarbonDioxide = $urandom;
    volatileOrganicTotal = $urandom;
    d = 3'($urandom_range(7, 1));
    repeat (6) @(negedge sys_clk);
    nrst = 1;
    chk("mode", 0, status.appMode);
    chk("id", sensor_boot_pkg::HW_IDENTITY_VAL, hardwareIdentity);
    if (hardwareIdentity !== sensor_boot_pkg::HW_IDENTITY_VAL) complete_run;
    chk("fwv", 0, status.fwValid);
    // launch with no image must be refused
    h.send('{launch: 1'b1, default: '0});
    chk("mode", 0, status.appMode);
    h.send('{cfgWrite: 1'b1, cfgDrive: d, cfgIrqEn: 1'b1, default: '0});
    h.send('{readStart: 1'b1, default: '0});
    chk("drive", 0, driveMode);
    chk("rv", 0, readValid);
    fwImagePresent = 1;
    #1 chk("fwv", 1, status.fwValid);
    h.send('{launch: 1'b1, default: '0});
    chk("mode", 1, status.appMode);
    fwImagePresent = 0;
    #1 chk("fwv", 1, status.fwValid);
    h.send('{cfgWrite: 1'b1, cfgDrive: d, cfgIrqEn: 1'b1, default: '0});
    chk("drive", d, driveMode);
    // one sample period plus margin
    for (i = 0; i < 26000 && status.dataReady !== 1'b1; i++) @(negedge sys_clk);
    chk("rdy", 1, status.dataReady);
    if (status.dataReady !== 1'b1) complete_run;
    chk("irq", 0, irqOutLow);
    h.send('{readStart: 1'b1, default: '0});
    for (i = 0; i < 4; i++) begin
      chk("byte", exp_byte(i), readByte);
      chk("rv", 1, readValid);
      h.send('{readNext: 1'b1, default: '0});
    end
    chk("rv", 0, readValid);
    complete_run;
  end
endmodule
bind boot_to_app_init boot_to_app_init_checker chk_i (.*);
`default_nettype wire

// ### tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side: one request pulse per call, launched off the falling edge
module host_model (
  input  wire logic                 sys_clk,
  output sensor_boot_pkg::hostReq_t hostReq
);
  initial hostReq = '0;
  task automatic send(input sensor_boot_pkg::hostReq_t r);
    @(negedge sys_clk) hostReq = r;
    @(negedge sys_clk) hostReq = '0;
  endtask
endmodule
`default_nettype wire
